// ### logic/pin_mux_pkg.sv
// constants, types and helpers shared by the shared-pad pin multiplexer
//
// Overview of operation
// - after reset the port B bit 4 pad is a GPIO input with pullup on
// - every shared pin is separately programmable as GPIO input or output
// - clearing port B pullup bit 4 switches off that pad's pullup
// - clearing the port B bit 4 GPIO-owner bit hands the pad to a peripheral
// - in peripheral mode clock-output select picks address line 20 or prescaled clock
// - drive-select decides if address line 20 floats while external bus idles
// - drive-select, gated by mem_data_oe, decides if data lines 7 to 10 float while bus idles
// - port F pads undriven with pullups in reset, then default to data bus
// - clearing port F pullup bit n switches off pin n pullup
// - port D pins 0 to 5 can carry chip selects 2 to 7
// - drive-select decides if chip selects 2 to 7 float while bus idles
// - after reset port D pins 0 to 5 are GPIO inputs with pullups on
// - clearing port D pullup bit n switches off pin n pullup

package pin_mux_pkg;

	// =========================================================
	// pin counts and pad synchroniser depth
	localparam int PORT_F_PINS     = 4;
	localparam int PORT_D_PINS     = 6;
	localparam int PAD_SYNC_STAGES = 2;

	// =========================================================
	// values after reset; owner bit 1 means GPIO owns the pad
	localparam logic       PORT_B_OWNER_RST  = 1'b1;
	localparam logic       PORT_B_DIR_RST    = 1'b0;
	localparam logic       PORT_B_DATA_RST   = 1'b0;
	localparam logic       PORT_B_PULLUP_RST = 1'b1;
	localparam logic [3:0] PORT_F_OWNER_RST  = 4'h0;
	localparam logic [3:0] PORT_F_DIR_RST    = 4'h0;
	localparam logic [3:0] PORT_F_DATA_RST   = 4'h0;
	localparam logic [3:0] PORT_F_PULLUP_RST = 4'hf;
	localparam logic [5:0] PORT_D_OWNER_RST  = 6'h3f;
	localparam logic [5:0] PORT_D_DIR_RST    = 6'h00;
	localparam logic [5:0] PORT_D_DATA_RST   = 6'h00;
	localparam logic [5:0] PORT_D_PULLUP_RST = 6'h3f;
	localparam logic       BUS_DRIVE_RST     = 1'b0;

	// =========================================================
	// source of port B bit 4 in peripheral mode
	typedef enum logic {
		clko_address,
		clko_prescaler
	} clko_src_t;

	localparam clko_src_t CLKO_SEL_RST = clko_address;

	// =========================================================
	// bus pads drive while the bus is busy, or always when drive-select is set
	function automatic logic bus_pad_drive(input logic bus_active, input logic drive_sel);
		bus_pad_drive = bus_active | drive_sel;
	endfunction : bus_pad_drive

endpackage : pin_mux_pkg

// ### logic/pad_mux_cell.sv
// one group of shared pads: owner mux, registered pad controls, input synchroniser
`timescale 1ns/1ps
`default_nettype none

module pad_mux_cell
	import pin_mux_pkg::*;
#(
	parameter int               WIDTH      = 1,
	parameter logic [WIDTH-1:0] PULLUP_RST = '1
)
(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// configuration
	input  wire logic [WIDTH-1:0] gpio_owner,
	input  wire logic [WIDTH-1:0] gpio_dir,
	input  wire logic [WIDTH-1:0] gpio_data,
	input  wire logic [WIDTH-1:0] pullup_en,
	// peripheral side
	input  wire logic [WIDTH-1:0] periph_out,
	input  wire logic [WIDTH-1:0] periph_oe,
	// pads
	input  wire logic [WIDTH-1:0] pad_i,
	output logic      [WIDTH-1:0] pad_o,
	output logic      [WIDTH-1:0] pad_oe,
	output logic      [WIDTH-1:0] pad_pullup,
	output logic      [WIDTH-1:0] pad_in_sync
);

	logic [WIDTH-1:0] pad_oe_d;
	logic [WIDTH-1:0] pad_o_d;
	logic [WIDTH-1:0] sync_meta_q;
	logic [WIDTH-1:0] sync_q;

	// =========================================================
	// owner mux: a GPIO-owned bit never looks at the peripheral
	always_comb
	begin
		pad_oe_d = (gpio_owner & gpio_dir) | (~gpio_owner & periph_oe);
		pad_o_d  = (gpio_owner & gpio_data) | (~gpio_owner & periph_out);
	end

	// registered pad drive; reset leaves every driver off
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pad_oe <= '0;
			pad_o  <= '0;
		end
		else
		begin
			pad_oe <= pad_oe_d;
			pad_o  <= pad_o_d;
		end
	end

	// pullup follows its enable bit alone
	always_ff @(posedge clk)
	begin
		if (rst)
			pad_pullup <= PULLUP_RST;
		else
			pad_pullup <= pullup_en;
	end

	// pad inputs are asynchronous: two flops before anyone reads them
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sync_meta_q <= '0;
			sync_q      <= '0;
		end
		else
		begin
			sync_meta_q <= pad_i;
			sync_q      <= sync_meta_q;
		end
	end

	assign pad_in_sync = sync_q;

	// =========================================================
	// checks
	a_gpio_owns_drive: assert property (@(posedge clk) disable iff (rst)
		$past(!rst) |-> ((pad_oe & $past(gpio_owner)) == ($past(gpio_owner) & $past(gpio_dir))))
		else $error("gpio-owned pad drive does not follow direction");

	a_pullup_follows: assert property (@(posedge clk) disable iff (rst)
		$past(!rst) |-> pad_pullup == $past(pullup_en))
		else $error("pullup does not follow its enable");

	a_reset_undriven: assert property (@(posedge clk)
		$past(rst) |-> (pad_oe == '0) && (pad_pullup == PULLUP_RST))
		else $error("pad not undriven with pullup after reset");

endmodule : pad_mux_cell

`default_nettype wire

// ### logic/ext_bus_gpio_pin_mux.sv
// shared pads between GPIO ports B4, F0-3, D0-5 and the external memory interface
`timescale 1ns/1ps
`default_nettype none

module ext_bus_gpio_pin_mux
	import pin_mux_pkg::*;
#(
	parameter int F_PINS = PORT_F_PINS,
	parameter int D_PINS = PORT_D_PINS
)
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// port B bit 4 configuration write
	input  wire logic              port_b_cfg_wr,
	input  wire logic              port_b_peripheral_enable_wd,
	input  wire logic              port_b_dir_wd,
	input  wire logic              port_b_data_wd,
	input  wire logic              port_b_pullup_enable_wd,
	// port F configuration write
	input  wire logic              port_f_cfg_wr,
	input  wire logic [F_PINS-1:0] port_f_peripheral_enable_wd,
	input  wire logic [F_PINS-1:0] port_f_dir_wd,
	input  wire logic [F_PINS-1:0] port_f_data_wd,
	input  wire logic [F_PINS-1:0] port_f_pullup_enable_wd,
	// port D configuration write
	input  wire logic              port_d_cfg_wr,
	input  wire logic [D_PINS-1:0] port_d_peripheral_enable_wd,
	input  wire logic [D_PINS-1:0] port_d_dir_wd,
	input  wire logic [D_PINS-1:0] port_d_data_wd,
	input  wire logic [D_PINS-1:0] port_d_pullup_enable_wd,
	// clock-output select and bus control write
	input  wire logic              ctrl_wr,
	input  wire logic              clock_output_select_wd,
	input  wire logic              bus_drive_select_wd,
	// configuration readback
	output logic                   port_b_peripheral_enable,
	output logic                   port_b_pullup_enable,
	output logic      [F_PINS-1:0] port_f_peripheral_enable,
	output logic      [F_PINS-1:0] port_f_pullup_enable,
	output logic      [D_PINS-1:0] port_d_peripheral_enable,
	output logic      [D_PINS-1:0] port_d_pullup_enable,
	output logic                   clock_output_select,
	output logic                   bus_drive_select,
	// synchronised pad levels for GPIO data reads
	output logic                   port_b_pin4_in,
	output logic      [F_PINS-1:0] port_f_pins_in,
	output logic      [D_PINS-1:0] port_d_pins_in,
	// external memory interface side
	input  wire logic              mem_bus_active,
	input  wire logic              address_line_20,
	input  wire logic [F_PINS-1:0] mem_data_out,
	input  wire logic              mem_data_oe,
	output logic      [F_PINS-1:0] mem_data_in,
	input  wire logic [D_PINS-1:0] chip_select,
	input  wire logic              prescaler_clock,
	// port B bit 4 pad
	input  wire logic              port_b_bit4_pad_i,
	output logic                   port_b_bit4_pad_o,
	output logic                   port_b_bit4_pad_oe,
	output logic                   port_b_bit4_pad_pu,
	// port F pads, data lines 7 to 10
	input  wire logic [F_PINS-1:0] port_f_pad_i,
	output logic      [F_PINS-1:0] port_f_pad_o,
	output logic      [F_PINS-1:0] port_f_pad_oe,
	output logic      [F_PINS-1:0] port_f_pad_pu,
	// port D pads, chip selects 2 to 7
	input  wire logic [D_PINS-1:0] port_d_pad_i,
	output logic      [D_PINS-1:0] port_d_pad_o,
	output logic      [D_PINS-1:0] port_d_pad_oe,
	output logic      [D_PINS-1:0] port_d_pad_pu
);

	// =========================================================
	// configuration registers
	logic              port_b_owner_q;
	logic              port_b_dir_q;
	logic              port_b_data_q;
	logic              port_b_pullup_q;
	logic [F_PINS-1:0] port_f_owner_q;
	logic [F_PINS-1:0] port_f_dir_q;
	logic [F_PINS-1:0] port_f_data_q;
	logic [F_PINS-1:0] port_f_pullup_q;
	logic [D_PINS-1:0] port_d_owner_q;
	logic [D_PINS-1:0] port_d_dir_q;
	logic [D_PINS-1:0] port_d_data_q;
	logic [D_PINS-1:0] port_d_pullup_q;
	clko_src_t         clko_sel_q;
	logic              bus_drive_q;

	// peripheral-side drive for each group
	logic              b4_periph_out;
	logic              b4_periph_oe;
	logic [F_PINS-1:0] f_periph_out;
	logic [F_PINS-1:0] f_periph_oe;
	logic [D_PINS-1:0] d_periph_out;
	logic [D_PINS-1:0] d_periph_oe;
	logic              bus_drive;

	// port B bit 4: comes out of reset as a GPIO input with its pullup on
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			port_b_owner_q  <= PORT_B_OWNER_RST;
			port_b_dir_q    <= PORT_B_DIR_RST;
			port_b_data_q   <= PORT_B_DATA_RST;
			port_b_pullup_q <= PORT_B_PULLUP_RST;
		end
		else if (port_b_cfg_wr)
		begin
			port_b_owner_q  <= port_b_peripheral_enable_wd;
			port_b_dir_q    <= port_b_dir_wd;
			port_b_data_q   <= port_b_data_wd;
			port_b_pullup_q <= port_b_pullup_enable_wd;
		end
	end

	// port F: data bus after reset, software is expected to move it to GPIO
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			port_f_owner_q  <= PORT_F_OWNER_RST;
			port_f_dir_q    <= PORT_F_DIR_RST;
			port_f_data_q   <= PORT_F_DATA_RST;
			port_f_pullup_q <= PORT_F_PULLUP_RST;
		end
		else if (port_f_cfg_wr)
		begin
			port_f_owner_q  <= port_f_peripheral_enable_wd;
			port_f_dir_q    <= port_f_dir_wd;
			port_f_data_q   <= port_f_data_wd;
			port_f_pullup_q <= port_f_pullup_enable_wd;
		end
	end

	// port D: GPIO inputs with pullups after reset
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			port_d_owner_q  <= PORT_D_OWNER_RST;
			port_d_dir_q    <= PORT_D_DIR_RST;
			port_d_data_q   <= PORT_D_DATA_RST;
			port_d_pullup_q <= PORT_D_PULLUP_RST;
		end
		else if (port_d_cfg_wr)
		begin
			port_d_owner_q  <= port_d_peripheral_enable_wd;
			port_d_dir_q    <= port_d_dir_wd;
			port_d_data_q   <= port_d_data_wd;
			port_d_pullup_q <= port_d_pullup_enable_wd;
		end
	end

	// clock-output select and bus drive-select
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			clko_sel_q  <= CLKO_SEL_RST;
			bus_drive_q <= BUS_DRIVE_RST;
		end
		else if (ctrl_wr)
		begin
			clko_sel_q  <= clko_src_t'(clock_output_select_wd);
			bus_drive_q <= bus_drive_select_wd;
		end
	end

	// =========================================================
	// peripheral muxing; idle bus floats unless drive-select holds it driven
	assign bus_drive = bus_pad_drive(mem_bus_active, bus_drive_q);

	always_comb
	begin
		unique case (clko_sel_q)
			clko_address:
			begin
				b4_periph_out = address_line_20;
				b4_periph_oe  = bus_drive;
			end
			clko_prescaler:
			begin
				// the monitor clock is free of bus state and always drives
				b4_periph_out = prescaler_clock;
				b4_periph_oe  = 1'b1;
			end
		endcase
	end

	// data lines drive only on a write cycle, and on an idle bus only while drive-select is set
	assign f_periph_out = mem_data_out;
	assign f_periph_oe  = {F_PINS{mem_data_oe & bus_pad_drive(mem_bus_active, bus_drive_q)}};

	// chip selects come straight from the memory interface decode
	assign d_periph_out = chip_select;
	assign d_periph_oe  = {D_PINS{bus_drive}};

	// =========================================================
	// pad groups
	pad_mux_cell #(
		.WIDTH      (1),
		.PULLUP_RST (PORT_B_PULLUP_RST)
	) u_port_b (
		.clk         (clk),
		.rst         (rst),
		.gpio_owner  (port_b_owner_q),
		.gpio_dir    (port_b_dir_q),
		.gpio_data   (port_b_data_q),
		.pullup_en   (port_b_pullup_q),
		.periph_out  (b4_periph_out),
		.periph_oe   (b4_periph_oe),
		.pad_i       (port_b_bit4_pad_i),
		.pad_o       (port_b_bit4_pad_o),
		.pad_oe      (port_b_bit4_pad_oe),
		.pad_pullup  (port_b_bit4_pad_pu),
		.pad_in_sync (port_b_pin4_in)
	);

	pad_mux_cell #(
		.WIDTH      (F_PINS),
		.PULLUP_RST (F_PINS'(PORT_F_PULLUP_RST))
	) u_port_f (
		.clk         (clk),
		.rst         (rst),
		.gpio_owner  (port_f_owner_q),
		.gpio_dir    (port_f_dir_q),
		.gpio_data   (port_f_data_q),
		.pullup_en   (port_f_pullup_q),
		.periph_out  (f_periph_out),
		.periph_oe   (f_periph_oe),
		.pad_i       (port_f_pad_i),
		.pad_o       (port_f_pad_o),
		.pad_oe      (port_f_pad_oe),
		.pad_pullup  (port_f_pad_pu),
		.pad_in_sync (port_f_pins_in)
	);

	pad_mux_cell #(
		.WIDTH      (D_PINS),
		.PULLUP_RST (D_PINS'(PORT_D_PULLUP_RST))
	) u_port_d (
		.clk         (clk),
		.rst         (rst),
		.gpio_owner  (port_d_owner_q),
		.gpio_dir    (port_d_dir_q),
		.gpio_data   (port_d_data_q),
		.pullup_en   (port_d_pullup_q),
		.periph_out  (d_periph_out),
		.periph_oe   (d_periph_oe),
		.pad_i       (port_d_pad_i),
		.pad_o       (port_d_pad_o),
		.pad_oe      (port_d_pad_oe),
		.pad_pullup  (port_d_pad_pu),
		.pad_in_sync (port_d_pins_in)
	);

	// =========================================================
	// readback and read data to the memory interface
	assign port_b_peripheral_enable = port_b_owner_q;
	assign port_b_pullup_enable     = port_b_pullup_q;
	assign port_f_peripheral_enable = port_f_owner_q;
	assign port_f_pullup_enable     = port_f_pullup_q;
	assign port_d_peripheral_enable = port_d_owner_q;
	assign port_d_pullup_enable     = port_d_pullup_q;
	assign clock_output_select      = clko_sel_q;
	assign bus_drive_select         = bus_drive_q;
	// read data is only meaningful while the pads belong to the bus
	assign mem_data_in              = port_f_pins_in;

	// =========================================================
	// checks
	a_b4_reset_gpio: assert property (@(posedge clk)
		$past(rst) |-> port_b_owner_q && !port_b_bit4_pad_oe && port_b_bit4_pad_pu)
		else $error("port B bit 4 not a GPIO input with pullup after reset");

	a_b4_pullup_off: assert property (@(posedge clk) disable iff (rst)
		port_b_cfg_wr && !port_b_pullup_enable_wd ##1 !port_b_cfg_wr |=> !port_b_bit4_pad_pu)
		else $error("port B bit 4 pullup still on after clear");

	a_b4_addr_select: assert property (@(posedge clk) disable iff (rst)
		!port_b_owner_q && clko_sel_q == clko_address && !$changed(port_b_owner_q)
		|=> port_b_bit4_pad_o == $past(address_line_20))
		else $error("port B bit 4 does not carry address line 20");

	a_b4_clock_select: assert property (@(posedge clk) disable iff (rst)
		!port_b_owner_q && clko_sel_q == clko_prescaler
		|=> port_b_bit4_pad_oe && port_b_bit4_pad_o == $past(prescaler_clock))
		else $error("port B bit 4 does not carry the prescaled clock");

	a_addr_idle_float: assert property (@(posedge clk) disable iff (rst)
		!port_b_owner_q && clko_sel_q == clko_address && !mem_bus_active && !bus_drive_q
		|=> !port_b_bit4_pad_oe)
		else $error("address line 20 driven on idle bus");

	a_data_idle_float: assert property (@(posedge clk) disable iff (rst)
		!mem_bus_active && !bus_drive_q |=> (port_f_pad_oe & ~$past(port_f_owner_q)) == '0)
		else $error("data lines driven on idle bus");

	a_cs_follow: assert property (@(posedge clk) disable iff (rst)
		port_d_owner_q == '0 && mem_bus_active
		|=> port_d_pad_oe == '1 && port_d_pad_o == $past(chip_select))
		else $error("chip selects do not follow the memory interface");

	a_cs_idle_float: assert property (@(posedge clk) disable iff (rst)
		!mem_bus_active && !bus_drive_q |=> (port_d_pad_oe & ~$past(port_d_owner_q)) == '0)
		else $error("chip selects driven on idle bus");

	a_f_reset_bus: assert property (@(posedge clk)
		$past(rst) |-> port_f_owner_q == '0 && port_f_pad_oe == '0 && port_f_pad_pu == '1)
		else $error("port F not data bus with pullups after reset");

	a_d_reset_gpio: assert property (@(posedge clk)
		$past(rst) |-> port_d_owner_q == '1 && port_d_pad_oe == '0 && port_d_pad_pu == '1)
		else $error("port D not GPIO inputs with pullups after reset");

	a_d_pullup_map: assert property (@(posedge clk) disable iff (rst)
		port_d_cfg_wr ##1 !port_d_cfg_wr |=> port_d_pad_pu == $past(port_d_pullup_enable_wd, 2))
		else $error("port D pullups not mapped bit for bit");

	c_b4_to_clock: cover property (@(posedge clk) disable iff (rst)
		!port_b_owner_q && clko_sel_q == clko_prescaler && port_b_bit4_pad_oe);

	c_f_to_gpio_out: cover property (@(posedge clk) disable iff (rst)
		port_f_owner_q == '1 && port_f_dir_q != '0);

	c_cs_idle_held: cover property (@(posedge clk) disable iff (rst)
		bus_drive_q && !mem_bus_active && port_d_pad_oe != '0);

endmodule : ext_bus_gpio_pin_mux

`default_nettype wire

// ### testbench/board_pads.sv
// board-side model of the shared pads: resolves drive, pullup and floating levels
`timescale 1ns/1ps
`default_nettype none

module board_pads
#(
	parameter int WIDTH = 1
)
(
	// clock
	input  wire logic             clk,
	// pad controls from the device
	input  wire logic [WIDTH-1:0] pad_o,
	input  wire logic [WIDTH-1:0] pad_oe,
	input  wire logic [WIDTH-1:0] pad_pu,
	// level seen back at the pad
	output logic      [WIDTH-1:0] pad_i
);
	// =========================================================
	// wire resolution
	logic [WIDTH-1:0] float_q = '0;

	// an unpulled released line wanders, so a stale value never reads back as valid
	always @(posedge clk)
		float_q <= ~pad_i;

	// device drive wins, then the pullup, then the wandering level
	assign pad_i = (pad_oe & pad_o) | (~pad_oe & pad_pu) | (~pad_oe & ~pad_pu & float_q);
endmodule : board_pads

`default_nettype wire

// ### testbench/ext_bus_gpio_pin_mux_tb.sv
// self-checking testbench for the shared-pad pin multiplexer
`timescale 1ns/1ps
`default_nettype none

module ext_bus_gpio_pin_mux_tb;
	// =========================================================
	// signals
	logic clk, rst, port_b_cfg_wr, port_b_peripheral_enable_wd, port_b_dir_wd, port_b_data_wd;
	logic port_b_pullup_enable_wd, port_f_cfg_wr, port_d_cfg_wr, ctrl_wr, clock_output_select_wd;
	logic bus_drive_select_wd, mem_bus_active, address_line_20, mem_data_oe, prescaler_clock;
	logic port_b_peripheral_enable, port_b_pullup_enable, clock_output_select, bus_drive_select;
	logic port_b_pin4_in, port_b_bit4_pad_i, port_b_bit4_pad_o, port_b_bit4_pad_oe;
	logic port_b_bit4_pad_pu;
	logic [3:0] port_f_peripheral_enable_wd, port_f_dir_wd, port_f_data_wd;
	logic [3:0] port_f_pullup_enable_wd, mem_data_out, port_f_peripheral_enable;
	logic [3:0] port_f_pullup_enable, port_f_pins_in, mem_data_in, port_f_pad_i, port_f_pad_o;
	logic [3:0] port_f_pad_oe, port_f_pad_pu;
	logic [5:0] port_d_peripheral_enable_wd, port_d_dir_wd, port_d_data_wd;
	logic [5:0] port_d_pullup_enable_wd, chip_select, port_d_peripheral_enable;
	logic [5:0] port_d_pullup_enable, port_d_pins_in, port_d_pad_i, port_d_pad_o;
	logic [5:0] port_d_pad_oe, port_d_pad_pu;
	int n_fail = 0;
	int cmp_count = 0;

	// =========================================================
	// design and board
	ext_bus_gpio_pin_mux dut (
		.clk, .rst, .port_b_cfg_wr, .port_b_peripheral_enable_wd, .port_b_dir_wd,
		.port_b_data_wd, .port_b_pullup_enable_wd, .port_f_cfg_wr, .port_f_peripheral_enable_wd,
		.port_f_dir_wd, .port_f_data_wd, .port_f_pullup_enable_wd, .port_d_cfg_wr,
		.port_d_peripheral_enable_wd, .port_d_dir_wd, .port_d_data_wd, .port_d_pullup_enable_wd,
		.ctrl_wr, .clock_output_select_wd, .bus_drive_select_wd, .port_b_peripheral_enable,
		.port_b_pullup_enable, .port_f_peripheral_enable, .port_f_pullup_enable,
		.port_d_peripheral_enable, .port_d_pullup_enable, .clock_output_select,
		.bus_drive_select, .port_b_pin4_in, .port_f_pins_in, .port_d_pins_in, .mem_bus_active,
		.address_line_20, .mem_data_out, .mem_data_oe, .mem_data_in, .chip_select,
		.prescaler_clock, .port_b_bit4_pad_i, .port_b_bit4_pad_o, .port_b_bit4_pad_oe,
		.port_b_bit4_pad_pu, .port_f_pad_i, .port_f_pad_o, .port_f_pad_oe, .port_f_pad_pu,
		.port_d_pad_i, .port_d_pad_o, .port_d_pad_oe, .port_d_pad_pu);
	board_pads #(.WIDTH(1)) pads_b (.clk(clk), .pad_o(port_b_bit4_pad_o),
		.pad_oe(port_b_bit4_pad_oe), .pad_pu(port_b_bit4_pad_pu), .pad_i(port_b_bit4_pad_i));
	board_pads #(.WIDTH(4)) pads_f (.clk(clk), .pad_o(port_f_pad_o), .pad_oe(port_f_pad_oe),
		.pad_pu(port_f_pad_pu), .pad_i(port_f_pad_i));
	board_pads #(.WIDTH(6)) pads_d (.clk(clk), .pad_o(port_d_pad_o), .pad_oe(port_d_pad_oe),
		.pad_pu(port_d_pad_pu), .pad_i(port_d_pad_i));

	// =========================================================
	// clock
	initial clk = 1'b0;
	always #25 clk = ~clk;

	// =========================================================
	// access tasks, each entered and left at a falling edge
	task automatic conclude();
		if (n_fail == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic settle();
		repeat (2) @(negedge clk);
	endtask : settle

	task automatic wr_b(input logic pe, input logic dir, input logic dat, input logic pu);
		{port_b_peripheral_enable_wd, port_b_dir_wd, port_b_data_wd} = {pe, dir, dat};
		port_b_pullup_enable_wd = pu;
		port_b_cfg_wr = 1'b1;
		@(negedge clk);
		port_b_cfg_wr = 1'b0;
	endtask : wr_b

	task automatic wr_f(input logic [3:0] pe, input logic [3:0] dir, input logic [3:0] dat,
		input logic [3:0] pu);
		{port_f_peripheral_enable_wd, port_f_dir_wd, port_f_data_wd} = {pe, dir, dat};
		port_f_pullup_enable_wd = pu;
		port_f_cfg_wr = 1'b1;
		@(negedge clk);
		port_f_cfg_wr = 1'b0;
	endtask : wr_f

	task automatic wr_d(input logic [5:0] pe, input logic [5:0] dir, input logic [5:0] dat,
		input logic [5:0] pu);
		{port_d_peripheral_enable_wd, port_d_dir_wd, port_d_data_wd} = {pe, dir, dat};
		port_d_pullup_enable_wd = pu;
		port_d_cfg_wr = 1'b1;
		@(negedge clk);
		port_d_cfg_wr = 1'b0;
	endtask : wr_d

	task automatic wr_ctrl(input logic sel, input logic drv);
		{clock_output_select_wd, bus_drive_select_wd} = {sel, drv};
		ctrl_wr = 1'b1;
		@(negedge clk);
		ctrl_wr = 1'b0;
	endtask : wr_ctrl

	task automatic mem_bus(input logic act, input logic addr, input logic [3:0] dout,
		input logic doe, input logic [5:0] cs);
		{mem_bus_active, address_line_20, mem_data_out, mem_data_oe} = {act, addr, dout, doe};
		chip_select = cs;
	endtask : mem_bus

	// =========================================================
	// watchdog, well beyond the 66 cycles the tests need
	initial
	begin
		#(3000 * 50);
		n_fail++;
		conclude();
	end

	// =========================================================
	// tests
	initial
	begin
		rst = 1'b1;
		{port_b_cfg_wr, port_b_peripheral_enable_wd, port_b_dir_wd, port_b_data_wd} = '0;
		{port_b_pullup_enable_wd, port_f_cfg_wr, port_d_cfg_wr, ctrl_wr} = '0;
		{clock_output_select_wd, bus_drive_select_wd, prescaler_clock} = '0;
		{port_f_peripheral_enable_wd, port_f_dir_wd, port_f_data_wd} = '0;
		{port_f_pullup_enable_wd, port_d_peripheral_enable_wd, port_d_dir_wd} = '0;
		{port_d_data_wd, port_d_pullup_enable_wd} = '0;
		mem_bus(1'b0, 1'b0, 4'h0, 1'b0, 6'h00);
		repeat (2) @(negedge clk);
		// pads inside reset, with a write that must be ignored
		chk("f_oe_in_rst", 8'h00, {4'h0, port_f_pad_oe});
		chk("f_pu_in_rst", 8'h0f, {4'h0, port_f_pad_pu});
		wr_b(1'b1, 1'b1, 1'b1, 1'b0);
		repeat (13) @(negedge clk);
		rst = 1'b0;
		settle();
		chk("b_pe_rst", 8'h01, {7'h0, port_b_peripheral_enable});
		chk("b_pu_rst", 8'h01, {7'h0, port_b_pullup_enable});
		chk("b_pads_rst", 8'h01, {6'h0, port_b_bit4_pad_oe, port_b_bit4_pad_pu});
		chk("b_in_rst", 8'h01, {7'h0, port_b_pin4_in});
		chk("f_pe_rst", 8'h00, {4'h0, port_f_peripheral_enable});
		chk("f_pu_rst", 8'h0f, {4'h0, port_f_pullup_enable});
		chk("d_pe_rst", 8'h3f, {2'h0, port_d_peripheral_enable});
		chk("d_pads_rst", 8'h3f, {2'h0, port_d_pad_pu});
		chk("d_oe_rst", 8'h00, {2'h0, port_d_pad_oe});
		chk("d_pu_rst", 8'h3f, {2'h0, port_d_pullup_enable});
		chk("ctrl_rst", 8'h00, {6'h0, clock_output_select, bus_drive_select});
		// port F on the data bus by default
		mem_bus(1'b1, 1'b0, 4'ha, 1'b1, 6'h00);
		settle();
		chk("f_bus_o", 8'h0a, {4'h0, port_f_pad_o});
		chk("f_bus_oe", 8'h0f, {4'h0, port_f_pad_oe});
		chk("d_gpio_oe", 8'h00, {2'h0, port_d_pad_oe});
		mem_bus(1'b0, 1'b0, 4'ha, 1'b1, 6'h00);
		settle();
		chk("f_idle_oe", 8'h00, {4'h0, port_f_pad_oe});
		wr_ctrl(1'b0, 1'b1);
		settle();
		chk("f_drv_oe", 8'h0f, {4'h0, port_f_pad_oe});
		// software moves port F to GPIO since the data bus is absent here
		wr_f(4'hf, 4'h5, 4'h3, 4'he);
		mem_bus(1'b1, 1'b0, 4'hc, 1'b1, 6'h00);
		settle();
		chk("f_gpio_oe", 8'h05, {4'h0, port_f_pad_oe});
		chk("f_gpio_o", 8'h01, {4'h0, port_f_pad_o & 4'h5});
		chk("f_pu_clr", 8'h0e, {4'h0, port_f_pad_pu});
		chk("f_rb", 8'hfe, {port_f_peripheral_enable, port_f_pullup_enable});
		repeat (4) @(negedge clk);
		chk("f_pins_in", 8'h01, {4'h0, port_f_pins_in & 4'h5});
		chk("f_mem_in", 8'h01, {4'h0, mem_data_in & 4'h5});
		// port B as GPIO output with pullup off
		wr_b(1'b1, 1'b1, 1'b1, 1'b0);
		settle();
		chk("b_gpio", 8'h06, {5'h0, port_b_bit4_pad_o, port_b_bit4_pad_oe, port_b_bit4_pad_pu});
		// port B released to address line 20
		wr_b(1'b0, 1'b0, 1'b0, 1'b0);
		wr_ctrl(1'b0, 1'b0);
		mem_bus(1'b1, 1'b1, 4'h0, 1'b0, 6'h00);
		settle();
		chk("b_addr_hi", 8'h03, {6'h0, port_b_bit4_pad_o, port_b_bit4_pad_oe});
		chk("b_rb", 8'h00, {6'h0, port_b_peripheral_enable, port_b_pullup_enable});
		mem_bus(1'b1, 1'b0, 4'h0, 1'b0, 6'h00);
		settle();
		chk("b_addr_lo", 8'h01, {6'h0, port_b_bit4_pad_o, port_b_bit4_pad_oe});
		mem_bus(1'b0, 1'b0, 4'h0, 1'b0, 6'h00);
		settle();
		chk("b_addr_idle", 8'h00, {7'h0, port_b_bit4_pad_oe});
		wr_ctrl(1'b0, 1'b1);
		settle();
		chk("b_addr_drv", 8'h01, {7'h0, port_b_bit4_pad_oe});
		// prescaled clock monitor drives even with the bus idle
		wr_ctrl(1'b1, 1'b0);
		prescaler_clock = 1'b1;
		settle();
		chk("b_clk_hi", 8'h03, {6'h0, port_b_bit4_pad_o, port_b_bit4_pad_oe});
		chk("ctrl_rb", 8'h02, {6'h0, clock_output_select, bus_drive_select});
		prescaler_clock = 1'b0;
		settle();
		chk("b_clk_lo", 8'h01, {6'h0, port_b_bit4_pad_o, port_b_bit4_pad_oe});
		// port D chip selects
		wr_d(6'h00, 6'h00, 6'h00, 6'h2a);
		mem_bus(1'b1, 1'b0, 4'h0, 1'b0, 6'h3e);
		settle();
		chk("d_cs_o", 8'h3e, {2'h0, port_d_pad_o});
		chk("d_cs_oe", 8'h3f, {2'h0, port_d_pad_oe});
		chk("d_pu_clr", 8'h2a, {2'h0, port_d_pad_pu});
		chk("d_rb_pu", 8'h2a, {2'h0, port_d_pullup_enable});
		chk("d_rb_pe", 8'h00, {2'h0, port_d_peripheral_enable});
		mem_bus(1'b0, 1'b0, 4'h0, 1'b0, 6'h3e);
		settle();
		chk("d_cs_idle", 8'h00, {2'h0, port_d_pad_oe});
		wr_ctrl(1'b0, 1'b1);
		settle();
		chk("d_cs_drv", 8'h3f, {2'h0, port_d_pad_oe});
		// back to GPIO: chip selects must no longer reach the pads
		wr_d(6'h3f, 6'h0f, 6'h05, 6'h3f);
		settle();
		chk("d_gpio_oe", 8'h0f, {2'h0, port_d_pad_oe});
		chk("d_gpio_o", 8'h05, {2'h0, port_d_pad_o & 6'h0f});
		repeat (4) @(negedge clk);
		chk("d_pins_in", 8'h05, {2'h0, port_d_pins_in & 6'h0f});
		conclude();
	end
endmodule : ext_bus_gpio_pin_mux_tb

`default_nettype wire
